//--- logic/igmc_pkg.sv
// Package with constants and types for the gain and mode control target
package igmc_pkg;

  // ************************************************************
  // Bus address
  // ************************************************************
  localparam logic [5:0] ADDR_UPPER = 6'h33;  // 110011

  // ************************************************************
  // Control byte fields and reset value
  // ************************************************************
  localparam int GAIN_MSB = 7;
  localparam int GAIN_LSB = 4;
  localparam int PHG_BIT = 3;
  localparam int MODE_MSB = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;   // Gain 0000 is standby
  localparam logic [3:0] GAIN_STANDBY = 4'h0;
  localparam logic [3:0] GAIN_UNDEF = 4'hf;
  localparam logic [7:0] STATUS_THERMAL = 8'hf0;
  localparam logic [7:0] STATUS_POP = 8'hf1;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 250;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_PERIOD_CYC = (CLK_MHZ * 1000) / SCL_MAX_KHZ;

  // ************************************************************
  // Protocol states
  // ************************************************************
  typedef enum logic [2:0] {
    IGMC_IDLE,
    IGMC_ADDR,
    IGMC_ADDR_ACK,
    IGMC_WR_DATA,
    IGMC_WR_ACK,
    IGMC_RD_DATA,
    IGMC_RD_ACK
  } igmc_state_type;

endpackage

//--- logic/igmc_pins_if.sv
// Interface carrying conditioned bus events between internal modules
`timescale 1ns/1ps
interface igmc_pins_if;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start;
  logic stop;
  modport source (output scl_rise, output scl_fall, output sda,
    output start, output stop);
  modport sink (input scl_rise, input scl_fall, input sda,
    input start, input stop);
endinterface

//--- logic/igmc_sync.sv
// Two-flop synchroniser and edge finder for the serial clock and data
`timescale 1ns/1ps
module igmc_sync
  import igmc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Raw pins
  input wire logic i_scl,
  input wire logic i_sda,
  // Conditioned events
  igmc_pins_if.source ev
);

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_last_reg;
  logic sda_last_reg;

  // Two flops per line; only the second is read
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      scl_last_reg <= scl_sync_reg[1];
      sda_last_reg <= sda_sync_reg[1];
    end
  end

  // Start and stop are data edges while the clock stays high
  assign ev.scl_rise = scl_sync_reg[1] & ~scl_last_reg;
  assign ev.scl_fall = ~scl_sync_reg[1] & scl_last_reg;
  assign ev.sda = sda_sync_reg[1];
  assign ev.start = scl_sync_reg[1] & scl_last_reg & sda_last_reg
    & ~sda_sync_reg[1];
  assign ev.stop = scl_sync_reg[1] & scl_last_reg & ~sda_last_reg
    & sda_sync_reg[1];

endmodule

//--- logic/igmc_target.sv
// I2C target with one control byte steering gain, mode and phantom ground
`timescale 1ns/1ps
module igmc_target
  import igmc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Serial bus pins, clock is input only
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Address select pin
  input wire logic i_addr_select,
  // Status from the analog side
  input wire logic i_thermal_shutdown,
  input wire logic i_pop_reduction,
  // Decoded controls to the amplifier
  output logic [3:0] o_gain_code,
  output logic o_standby,
  output logic o_gain_undefined,
  output logic o_phantom_ground_enable,
  output logic [2:0] o_output_mode,
  output logic [1:0] o_channel_shutdown,
  output logic [7:0] o_control,
  output logic o_write_strobe
);

  // ************************************************************
  // Pin conditioning
  // ************************************************************
  igmc_pins_if ev ();

  // Clock line sampled like any other pin; the target never stretches it
  igmc_sync u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .ev(ev)
  );

  // Status flags and address select pin each sampled through two flops as they come in
  logic [1:0] thermal_sync_reg;
  logic [1:0] pop_sync_reg;
  logic [1:0] addr_sel_sync_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      thermal_sync_reg <= 2'h0;
      pop_sync_reg <= 2'h0;
      addr_sel_sync_reg <= 2'h0;
    end
    else
    begin
      thermal_sync_reg <= {thermal_sync_reg[0], i_thermal_shutdown};
      pop_sync_reg <= {pop_sync_reg[0], i_pop_reduction};
      addr_sel_sync_reg <= {addr_sel_sync_reg[0], i_addr_select};
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  // Address match on the seven upper bits of the first byte
  function automatic logic addr_match(input logic [7:0] b, input logic sel);
    addr_match = (b[7:2] == ADDR_UPPER) && (b[1] == sel);
  endfunction

  // Channel shutdown pattern for a mode field; modes 5-8 silence one side
  function automatic logic [1:0] mode_shutdown(input logic [2:0] m);
    case (m)
      3'h4, 3'h5: mode_shutdown = 2'h1;
      3'h6, 3'h7: mode_shutdown = 2'h2;
      default: mode_shutdown = 2'h0;
    endcase
  endfunction

  // ************************************************************
  // Protocol engine
  // ************************************************************
  igmc_state_type state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] tx_reg;
  logic sda_oe_reg;
  logic wr_strobe_reg;
  logic master_ack_reg;

  // Value handed to the master on a read
  logic [7:0] read_value;
  always_comb
  begin
    if (thermal_sync_reg[1])
      read_value = STATUS_THERMAL;
    else if (pop_sync_reg[1])
      read_value = STATUS_POP;
    else
      read_value = ctrl_reg;
  end

  // Bit shifting happens on clock rise; data line changes on clock fall
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg <= IGMC_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      tx_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      master_ack_reg <= 1'b0;
    end
    else if (ev.start)
    begin
      // Repeated start restarts address phase from any state
      state_reg <= IGMC_ADDR;
      bit_cnt_reg <= 3'h0;
      // Stale byte would be taken for an address at the start's clock fall
      shift_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
    end
    else if (ev.stop)
    begin
      state_reg <= IGMC_IDLE;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        IGMC_IDLE:
        begin
          sda_oe_reg <= 1'b0;
        end
        IGMC_ADDR, IGMC_WR_DATA:
        begin
          if (ev.scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], ev.sda};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
          if (ev.scl_fall && bit_cnt_reg == 3'h0 && sda_oe_reg)
            sda_oe_reg <= 1'b0;
          else if (ev.scl_fall && bit_cnt_reg == 3'h0 &&
            state_reg == IGMC_ADDR && !sda_oe_reg && shift_reg != 8'h00)
          begin
            // Eighth bit in: match address, else ignore the transfer
            if (addr_match(shift_reg, addr_sel_sync_reg[1]))
            begin
              sda_oe_reg <= 1'b1;
              state_reg <= IGMC_ADDR_ACK;
            end
            else
              state_reg <= IGMC_IDLE;
          end
          else if (ev.scl_fall && bit_cnt_reg == 3'h0 &&
            state_reg == IGMC_WR_DATA && !sda_oe_reg)
          begin
            sda_oe_reg <= 1'b1;
            state_reg <= IGMC_WR_ACK;
          end
        end
        IGMC_ADDR_ACK, IGMC_WR_ACK:
        begin
          // Ack bit held low until the ninth clock falls
          if (ev.scl_fall)
          begin
            bit_cnt_reg <= 3'h0;
            if (state_reg == IGMC_ADDR_ACK && shift_reg[0])
            begin
              state_reg <= IGMC_RD_DATA;
              tx_reg <= {read_value[6:0], 1'b0};
              sda_oe_reg <= ~read_value[7];
            end
            else
            begin
              state_reg <= IGMC_WR_DATA;
              sda_oe_reg <= 1'b0;
              shift_reg <= 8'h00;
            end
          end
        end
        IGMC_RD_DATA:
        begin
          if (ev.scl_rise)
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (ev.scl_fall)
          begin
            if (bit_cnt_reg == 3'h0)
            begin
              // Release for the master's ack bit
              sda_oe_reg <= 1'b0;
              state_reg <= IGMC_RD_ACK;
            end
            else
            begin
              sda_oe_reg <= ~tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
        end
        IGMC_RD_ACK:
        begin
          if (ev.scl_rise)
            master_ack_reg <= ~ev.sda;
          if (ev.scl_fall)
          begin
            if (master_ack_reg)
            begin
              // Same value again, no address increment
              state_reg <= IGMC_RD_DATA;
              bit_cnt_reg <= 3'h0;
              tx_reg <= {read_value[6:0], 1'b0};
              sda_oe_reg <= ~read_value[7];
            end
            else
              state_reg <= IGMC_IDLE;
          end
        end
        default:
        begin
          state_reg <= IGMC_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Control register
  // ************************************************************
  // Loaded when the ack of each written data byte begins
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ctrl_reg <= CTRL_RESET;
      wr_strobe_reg <= 1'b0;
    end
    else
    begin
      wr_strobe_reg <= 1'b0;
      if (state_reg == IGMC_WR_DATA && ev.scl_fall && bit_cnt_reg == 3'h0
        && !sda_oe_reg && !ev.start && !ev.stop)
      begin
        ctrl_reg <= shift_reg;
        wr_strobe_reg <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Decoded controls registered so every output leaves a flop
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_gain_code <= GAIN_STANDBY;
      o_standby <= 1'b1;
      o_gain_undefined <= 1'b0;
      o_phantom_ground_enable <= 1'b0;
      o_output_mode <= 3'h0;
      o_channel_shutdown <= 2'h3;
      o_control <= CTRL_RESET;
      o_write_strobe <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      o_gain_code <= ctrl_reg[GAIN_MSB:GAIN_LSB];
      o_standby <= (ctrl_reg[GAIN_MSB:GAIN_LSB] == GAIN_STANDBY);
      o_gain_undefined <= (ctrl_reg[GAIN_MSB:GAIN_LSB] == GAIN_UNDEF);
      o_phantom_ground_enable <= ctrl_reg[PHG_BIT];
      o_output_mode <= ctrl_reg[MODE_MSB:0];
      o_channel_shutdown <= (ctrl_reg[GAIN_MSB:GAIN_LSB] == GAIN_STANDBY)
        ? 2'h3 : mode_shutdown(ctrl_reg[MODE_MSB:0]);
      o_control <= ctrl_reg;
      o_write_strobe <= wr_strobe_reg;
      o_sda_out <= 1'b0;
      o_sda_oe <= sda_oe_reg;
    end
  end

endmodule

//--- dv/igmc_target_props.sv
// Checker of the gain and mode control target's port behaviour
`timescale 1ns/1ps
module igmc_target_props
  import igmc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Bus pins and straps
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_addr_select,
  input wire logic i_thermal_shutdown,
  input wire logic i_pop_reduction,
  // Decoded controls
  input wire logic [3:0] o_gain_code,
  input wire logic o_standby,
  input wire logic o_gain_undefined,
  input wire logic o_phantom_ground_enable,
  input wire logic [2:0] o_output_mode,
  input wire logic [1:0] o_channel_shutdown,
  input wire logic [7:0] o_control,
  input wire logic o_write_strobe
);
  // ************************************************************
  // Assertions, all in the one clock domain
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // A driven data line may only ever be low
  a_drive_only_low: assert property (o_sda_oe |-> !o_sda_out)
    else $error("data line driven high");
  // First edge after reset still shows the power-up state
  a_reset_state: assert property ($fell(i_reset) |->
    o_control == CTRL_RESET && o_standby && o_channel_shutdown == 2'h3
    && !o_sda_oe && !o_write_strobe)
    else $error("state after reset wrong");
  a_standby_decode: assert property
    (o_standby == (o_gain_code == GAIN_STANDBY))
    else $error("standby flag wrong");
  a_undef_decode: assert property
    (o_gain_undefined == (o_gain_code == GAIN_UNDEF))
    else $error("undefined flag wrong");
  // Decoded fields settle within two cycles of the strobe
  a_gain_follows: assert property (o_write_strobe |->
    ##[1:2] o_gain_code == o_control[7:4])
    else $error("gain does not follow control");
  a_mode_follows: assert property (o_write_strobe |-> ##[1:2]
    (o_output_mode == o_control[2:0]
    && o_phantom_ground_enable == o_control[3]))
    else $error("mode does not follow control");
  a_standby_mute: assert property
    (o_standby |-> o_channel_shutdown == 2'h3)
    else $error("standby leaves a channel on");
  // Modes five to eight switch one output off
  a_mode_mute: assert property (!o_standby |->
    o_channel_shutdown == (o_output_mode[2] ?
    {o_output_mode[1], !o_output_mode[1]} : 2'h0))
    else $error("channel shutdown map wrong");
  a_load_strobe: assert property ($changed(o_control) |->
    o_write_strobe ##1 !o_write_strobe)
    else $error("control changed without strobe");
endmodule
bind igmc_target igmc_target_props igmc_target_props_inst (.*);

//--- dv/igmc_master_model.sv
// Bus master model that frames transfers on the serial lines
`timescale 1ns/1ps
module igmc_master_model
(
  // Serial lines, a high drive means released
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  // Clock stands still high between frames
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Start or repeated start, data falls while clock high
  task automatic bus_start();
    #4 o_sda = 1'b1;
    #8 o_scl = 1'b1;
    #8 o_sda = 1'b0;
    #8 o_scl = 1'b0;
  endtask
  // Stop, data rises while clock high
  task automatic bus_stop();
    #8 o_sda = 1'b0;
    #8 o_scl = 1'b1;
    #8 o_sda = 1'b1;
    #8;
  endtask
  // Data changes mid-low and is sampled mid-high, away from both edges
  task automatic bit_io(input logic b, output logic r);
    #8 o_sda = b;
    #8 o_scl = 1'b1;
    #8 r = i_sda;
    #8 o_scl = 1'b0;
  endtask
  // Byte out, ack high when the target pulled the ninth bit low
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in, then acknowledge, or release on the last byte
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
endmodule

//--- dv/testbench.sv
// Self-checking bench for the gain and mode control target
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  import igmc_pkg::*;
  typedef struct packed
  {
    logic [7:0] d;
    logic [1:0] sd;
    logic stby;
    logic undef;
  } igmc_row_type;
  // Written byte beside the decoded outputs it should give
  localparam igmc_row_type rows [10] = '{
    '{8'h10, 2'h0, 1'b0, 1'b0}, '{8'he9, 2'h0, 1'b0, 1'b0},
    '{8'h52, 2'h0, 1'b0, 1'b0}, '{8'h63, 2'h0, 1'b0, 1'b0},
    '{8'h74, 2'h1, 1'b0, 1'b0}, '{8'h85, 2'h1, 1'b0, 1'b0},
    '{8'h2e, 2'h2, 1'b0, 1'b0}, '{8'h3f, 2'h2, 1'b0, 1'b0},
    '{8'h0b, 2'h3, 1'b1, 1'b0}, '{8'hf2, 2'h0, 1'b0, 1'b1}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic therm = 1'b0;
  logic pop = 1'b0;
  logic m_scl, m_sda, oe, sout, stb, stby, undef, phantom_ground_enable;
  logic [3:0] gain;
  logic [2:0] mode;
  logic [1:0] sd;
  logic [7:0] ctrl;
  int errors = 0;
  int checks_done = 0;
  int strobes = 0;
  int strobes_base = 0;
  // Wired-AND with pull-up: released by all means high
  wire sda = m_sda & !(oe & !sout);
  always #2 clk = ~clk;
  always @(posedge clk) if (stb === 1'b1) strobes++;
  igmc_target igmc_target_inst (.i_clk(clk), .i_reset(rst),
    .i_scl(m_scl), .i_sda(sda), .o_sda_out(sout), .o_sda_oe(oe),
    .i_addr_select(sel), .i_thermal_shutdown(therm),
    .i_pop_reduction(pop), .o_gain_code(gain), .o_standby(stby),
    .o_gain_undefined(undef), .o_phantom_ground_enable(phantom_ground_enable),
    .o_output_mode(mode), .o_channel_shutdown(sd), .o_control(ctrl),
    .o_write_strobe(stb));
  igmc_master_model igmc_master_model_inst (.o_scl(m_scl),
    .o_sda(m_sda), .i_sda(sda));
  // Inputs move one nanosecond after the edge, never on it
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [23:0] d, int n, logic ea);
    logic k;
    igmc_master_model_inst.bus_start();
    igmc_master_model_inst.send_byte(a, k);
    `CHK(k, ea)
    for (int i = n - 1; i >= 0; i--)
    begin
      igmc_master_model_inst.send_byte(d[i*8+:8], k);
      `CHK(k, ea)
    end
    igmc_master_model_inst.bus_stop();
    step(2);
  endtask
  task automatic rd(logic [7:0] a, int n, logic [7:0] e);
    logic k;
    logic [7:0] b;
    igmc_master_model_inst.bus_start();
    igmc_master_model_inst.send_byte(a, k);
    `CHK(k, 1'b1)
    for (int i = 0; i < n; i++)
    begin
      igmc_master_model_inst.get_byte(i == n - 1, b);
      `CHK(b, e)
    end
    igmc_master_model_inst.bus_stop();
    step(2);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    step(10);
    rst = 1'b0;
    step(1);
    `CHK(ctrl, CTRL_RESET)
    `CHK(sd, 2'h3)
    `CHK(oe, 1'b0)
    step(4);
    rd(8'hcd, 1, 8'h00);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(8'hcc, rows[i].d, 1, 1'b1);
      `CHK(gain, rows[i].d[7:4])
      `CHK(mode, rows[i].d[2:0])
      `CHK(phantom_ground_enable, rows[i].d[3])
      `CHK(sd, rows[i].sd)
      `CHK(stby, rows[i].stby)
      `CHK(undef, rows[i].undef)
      rd(8'hcd, 1, rows[i].d);
    end
    $display("row test done");
    strobes_base = strobes;
    wr(8'hcc, 24'h1a2b96, 3, 1'b1);
    `CHK(strobes - strobes_base, 3)
    `CHK(ctrl, 8'h96)
    rd(8'hcd, 3, 8'h96);
    $display("burst test done");
    // Foreign address: no ack and the data byte must not land
    wr(8'hce, 8'h41, 1, 1'b0);
    `CHK(ctrl, 8'h96)
    sel = 1'b1;
    step(4);
    wr(8'hcc, 8'h41, 1, 1'b0);
    wr(8'hce, 8'h41, 1, 1'b1);
    rd(8'hcf, 1, 8'h41);
    $display("address test done");
    therm = 1'b1;
    pop = 1'b1;
    step(4);
    rd(8'hcf, 2, STATUS_THERMAL);
    therm = 1'b0;
    step(4);
    rd(8'hcf, 1, STATUS_POP);
    pop = 1'b0;
    step(4);
    rd(8'hcf, 1, 8'h41);
    $display("status test done");
    rst = 1'b1;
    step(10);
    rst = 1'b0;
    step(1);
    `CHK(ctrl, CTRL_RESET)
    `CHK(stby, 1'b1)
    $display("second reset test done");
    tally_and_finish();
  end
  // The sequence needs some 20 us; four times that cuts a hang short
  initial
  begin
    #80000;
    errors++;
    tally_and_finish();
  end
endmodule
